/* hw/fpmv_params.svh */
// Constants for the floating-point register move unit
`ifndef FPMV_PARAMS_SVH
`define FPMV_PARAMS_SVH
// ==========================================
// Opcode patterns
`define FPMV_CMOV_OP 12'he6c
`define FPMV_TOFP_OP 8'hbd
`define FPMV_FROMFP_OP 8'hbf
`define FPMV_STFLD_OP 16'he280
// ==========================================
// Status register bit positions
`define FPMV_LVF_BIT 0
`define FPMV_LUF_BIT 1
`define FPMV_NF_BIT 2
`define FPMV_ZF_BIT 3
`define FPMV_NI_BIT 4
`define FPMV_ZI_BIT 5
`define FPMV_TF_BIT 6
// ==========================================
// Register word offsets (byte address bits 4:2)
`define FPMV_OFS_STATUS 3'h0
`define FPMV_OFS_IRQ_STAT 3'h1
`define FPMV_OFS_IRQ_MASK 3'h2
`define FPMV_OFS_CTRL 3'h3
`define FPMV_OFS_REG_SEL 3'h4
`define FPMV_OFS_REG_DATA 3'h5
// ==========================================
// Event bits of the interrupt status register
`define FPMV_EVT_MOVED 0
`define FPMV_EVT_SKIPPED 1
`define FPMV_EVT_RESVD 2
`define FPMV_EVT_STF_LOAD 3
`define FPMV_EVT_TO_CPU 4
`define FPMV_EVT_W 5
// ==========================================
// Reset values
`define FPMV_STF_RST 32'h0000_0000
`define FPMV_MASK_RST 5'h00
`define FPMV_CTRL_RST 1'h1
`endif

/* hw/fpmv_pkg.sv */
// Types shared by the floating-point register move unit
package fpmv_pkg;
    // ==========================================
    // Move condition encodings
    typedef enum logic [3:0] {
        cond_nonzero = 4'h0,
        cond_zero = 4'h1,
        cond_positive = 4'h2,
        cond_nonnegative = 4'h3,
        cond_negative = 4'h4,
        cond_nonpositive = 4'h5,
        cond_test_set = 4'ha,
        cond_test_clear = 4'hb,
        cond_underflow = 4'hc,
        cond_overflow = 4'hd,
        uncond_no_flag = 4'he,
        uncond_flag_update = 4'hf
    } fpmv_cond_t;
endpackage : fpmv_pkg

/* hw/fpmv_cond_eval.sv */
// Move condition evaluator
`timescale 1ns/1ps
`default_nettype none
module fpmv_cond_eval (
    // Condition field
    input wire logic [3:0] move_condition,
    // Flags under test
    input wire logic fp_zero_flag,
    input wire logic fp_neg_flag,
    input wire logic test_flag,
    input wire logic latched_underflow_flag,
    input wire logic latched_overflow_flag,
    // Verdict
    output logic cond_true,
    output logic flag_update,
    output logic cond_reserved
);
    // ==========================================
    // Evaluation
    always_comb begin
        cond_true = 1'b0;
        flag_update = 1'b0;
        cond_reserved = 1'b0;
        case (fpmv_pkg::fpmv_cond_t'(move_condition))
            fpmv_pkg::cond_nonzero: cond_true = !fp_zero_flag;
            fpmv_pkg::cond_zero: cond_true = fp_zero_flag;
            fpmv_pkg::cond_positive: cond_true = !fp_zero_flag && !fp_neg_flag;
            fpmv_pkg::cond_nonnegative: cond_true = !fp_neg_flag;
            fpmv_pkg::cond_negative: cond_true = fp_neg_flag;
            // Both flags set, kept exactly as encoded
            fpmv_pkg::cond_nonpositive: cond_true = fp_zero_flag && fp_neg_flag;
            fpmv_pkg::cond_test_set: cond_true = test_flag;
            fpmv_pkg::cond_test_clear: cond_true = !test_flag;
            fpmv_pkg::cond_underflow: cond_true = latched_underflow_flag;
            fpmv_pkg::cond_overflow: cond_true = latched_overflow_flag;
            fpmv_pkg::uncond_no_flag: cond_true = 1'b1;
            fpmv_pkg::uncond_flag_update: begin
                cond_true = 1'b1;
                flag_update = 1'b1;
            end
            // Reserved codes never move, so a stray code cannot corrupt a register
            default: cond_reserved = 1'b1;
        endcase
    end
endmodule : fpmv_cond_eval
`default_nettype wire

/* hw/fpmv_top.sv */
// Floating-point register move unit with Avalon-MM register slave
`include "fpmv_params.svh"
`timescale 1ns/1ps
`default_nettype none
module fpmv_top #(
    parameter int NUM_FP_REGS = 8,
    parameter int DATA_W = 32
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Instruction issue from the CPU pipeline
    input wire logic instr_valid,
    input wire logic [15:0] lower_opcode_word,
    input wire logic [15:0] upper_opcode_word,
    input wire logic [DATA_W-1:0] cpu_src_data,
    input wire logic [DATA_W-1:0] mem_rd_data,
    // Write-back to a CPU register
    output logic cpu_wr_valid_r,
    output logic [7:0] cpu_wr_loc_r,
    output logic [DATA_W-1:0] cpu_wr_data_r,
    // Status register view
    output logic [DATA_W-1:0] fpu_status_reg_r,
    // Avalon-MM slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Interrupt
    output logic irq_r
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    // ==========================================
    // Storage
    logic [DATA_W-1:0] fp_regs_r [NUM_FP_REGS];
    logic [DATA_W-1:0] stf_r;
    logic [`FPMV_EVT_W-1:0] irq_stat_r;
    logic [`FPMV_EVT_W-1:0] irq_stat_nxt;
    logic [`FPMV_EVT_W-1:0] irq_mask_r;
    logic enable_r;
    logic [2:0] reg_sel_r;
    logic [31:0] rdata_r;
    logic wait_r;

    // ==========================================
    // Decode; no hazard checks, the issuing program spaces dependent moves
    logic is_cmov;
    logic is_to_fp;
    logic is_from_fp;
    logic is_stf_ld;
    logic [3:0] move_condition;
    logic [2:0] fp_dest_reg;
    logic [2:0] fp_src_reg;
    logic [2:0] fp_xfer_reg;
    logic [7:0] cpu_reg_locator;
    logic [DATA_W-1:0] src_val;
    logic [DATA_W-1:0] dest_val;
    logic [DATA_W-1:0] xfer_val;

    assign move_condition = lower_opcode_word[3:0];
    assign fp_dest_reg = upper_opcode_word[2:0];
    assign fp_src_reg = upper_opcode_word[5:3];
    assign fp_xfer_reg = upper_opcode_word[2:0];
    assign cpu_reg_locator = lower_opcode_word[7:0];
    assign src_val = fp_regs_r[fp_src_reg];
    assign dest_val = fp_regs_r[fp_dest_reg];
    assign xfer_val = fp_regs_r[fp_xfer_reg];

    always_comb begin
        is_cmov = instr_valid && enable_r
            && lower_opcode_word[15:4] == `FPMV_CMOV_OP
            && upper_opcode_word[15:6] == 10'h000;
        is_to_fp = instr_valid && enable_r
            && lower_opcode_word[15:8] == `FPMV_TOFP_OP;
        is_from_fp = instr_valid && enable_r
            && lower_opcode_word[15:8] == `FPMV_FROMFP_OP;
        is_stf_ld = instr_valid && enable_r
            && lower_opcode_word == `FPMV_STFLD_OP
            && upper_opcode_word[15:8] == 8'h00;
    end

    // ==========================================
    // Condition evaluation
    logic cond_true;
    logic flag_update;
    logic cond_reserved;

    fpmv_cond_eval fpmv_cond_eval_i (
        .move_condition(move_condition),
        .fp_zero_flag(stf_r[`FPMV_ZF_BIT]),
        .fp_neg_flag(stf_r[`FPMV_NF_BIT]),
        .test_flag(stf_r[`FPMV_TF_BIT]),
        .latched_underflow_flag(stf_r[`FPMV_LUF_BIT]),
        .latched_overflow_flag(stf_r[`FPMV_LVF_BIT]),
        .cond_true(cond_true),
        .flag_update(flag_update),
        .cond_reserved(cond_reserved)
    );

    logic cmov_take;
    assign cmov_take = is_cmov && cond_true;

    // ==========================================
    // Floating-point register file
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            for (int i = 0; i < NUM_FP_REGS; i++) begin
                fp_regs_r[i] <= '0;
            end
        end else if (cmov_take) begin
            fp_regs_r[fp_dest_reg] <= src_val;
        end else if (is_to_fp) begin
            // Aux, temp, accumulator and product all arrive as one value
            fp_regs_r[fp_xfer_reg] <= cpu_src_data;
        end
    end

    // ==========================================
    // Status flags
    logic [DATA_W-1:0] stf_nxt;
    always_comb begin
        stf_nxt = stf_r;
        if (is_stf_ld) begin
            stf_nxt = mem_rd_data;
        end else if (cmov_take && flag_update) begin
            stf_nxt[`FPMV_NF_BIT] = src_val[31] && (src_val[30:23] != 8'h00);
            stf_nxt[`FPMV_ZF_BIT] = src_val[30:23] == 8'h00;
            stf_nxt[`FPMV_NI_BIT] = src_val[31];
            stf_nxt[`FPMV_ZI_BIT] = src_val == '0;
        end
    end

    // CPU register moves fall through untouched
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            stf_r <= `FPMV_STF_RST;
        end else begin
            stf_r <= stf_nxt;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            fpu_status_reg_r <= `FPMV_STF_RST;
        end else begin
            fpu_status_reg_r <= stf_nxt;
        end
    end

    // ==========================================
    // Write-back toward the CPU
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cpu_wr_valid_r <= 1'b0;
            cpu_wr_loc_r <= 8'h00;
            cpu_wr_data_r <= '0;
        end else begin
            cpu_wr_valid_r <= is_from_fp;
            if (is_from_fp) begin
                cpu_wr_loc_r <= cpu_reg_locator;
                cpu_wr_data_r <= xfer_val;
            end
        end
    end

    // ==========================================
    // Events and interrupt
    logic [`FPMV_EVT_W-1:0] evt;
    logic stat_rd_clr;
    always_comb begin
        evt = '0;
        evt[`FPMV_EVT_MOVED] = cmov_take;
        evt[`FPMV_EVT_SKIPPED] = is_cmov && !cond_true;
        evt[`FPMV_EVT_RESVD] = is_cmov && cond_reserved;
        evt[`FPMV_EVT_STF_LOAD] = is_stf_ld;
        evt[`FPMV_EVT_TO_CPU] = is_from_fp;
    end
    assign stat_rd_clr = avs_read && !wait_r && avs_address[4:2] == `FPMV_OFS_IRQ_STAT;

    // A new event in the clearing cycle survives the clear
    always_comb begin
        irq_stat_nxt = (stat_rd_clr ? '0 : irq_stat_r) | evt;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            irq_stat_r <= '0;
        end else begin
            irq_stat_r <= irq_stat_nxt;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(irq_stat_nxt & irq_mask_r);
        end
    end

    // ==========================================
    // Avalon-MM slave: one wait cycle per access
    logic bus_req;
    logic bus_wr;
    assign bus_req = avs_read || avs_write;
    assign bus_wr = avs_write && !wait_r;
    assign avs_waitrequest = wait_r;
    assign avs_readdata = rdata_r;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wait_r <= 1'b1;
        end else begin
            wait_r <= !(bus_req && wait_r);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            irq_mask_r <= `FPMV_MASK_RST;
            enable_r <= `FPMV_CTRL_RST;
            reg_sel_r <= 3'h0;
        end else if (bus_wr) begin
            case (avs_address[4:2])
                `FPMV_OFS_IRQ_MASK: irq_mask_r <= avs_writedata[`FPMV_EVT_W-1:0];
                `FPMV_OFS_CTRL: enable_r <= avs_writedata[0];
                `FPMV_OFS_REG_SEL: reg_sel_r <= avs_writedata[2:0];
                default: begin
                end
            endcase
        end
    end

    // Read data is set up during the wait cycle
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rdata_r <= 32'h0000_0000;
        end else if (avs_read && wait_r) begin
            case (avs_address[4:2])
                `FPMV_OFS_STATUS: rdata_r <= stf_r;
                `FPMV_OFS_IRQ_STAT: rdata_r <= {27'h0, irq_stat_nxt};
                `FPMV_OFS_IRQ_MASK: rdata_r <= {27'h0, irq_mask_r};
                `FPMV_OFS_CTRL: rdata_r <= {31'h0, enable_r};
                `FPMV_OFS_REG_SEL: rdata_r <= {29'h0, reg_sel_r};
                `FPMV_OFS_REG_DATA: rdata_r <= fp_regs_r[reg_sel_r];
                default: rdata_r <= 32'h0000_0000;
            endcase
        end
    end

    // ==========================================
    // Checks
    chk_cmov_copy: assert property (
        cmov_take |=> fp_regs_r[$past(fp_dest_reg)] == $past(src_val))
        else $error("conditional move did not copy source");

    chk_cmov_skip: assert property (
        (is_cmov && !cond_true) |=> fp_regs_r[$past(fp_dest_reg)] == $past(dest_val))
        else $error("false condition changed destination");

    chk_cond_lt: assert property (
        (is_cmov && move_condition == 4'h4) |-> cond_true == stf_r[`FPMV_NF_BIT])
        else $error("negative condition misjudged");

    chk_flags_hold: assert property (
        (is_cmov && move_condition != 4'hf) |=> $stable(stf_r))
        else $error("flags changed without flag update code");

    chk_flag_sign: assert property (
        (is_cmov && move_condition == 4'hf) |=>
            stf_r[`FPMV_ZF_BIT] == ($past(src_val[30:23]) == 8'h00)
            && stf_r[`FPMV_NI_BIT] == $past(src_val[31])
            && stf_r[`FPMV_ZI_BIT] == ($past(src_val) == '0)
            && stf_r[`FPMV_NF_BIT] == ($past(src_val[31]) && $past(src_val[30:23]) != 8'h00))
        else $error("flag update wrong");

    chk_stf_load: assert property (
        is_stf_ld |=> stf_r == $past(mem_rd_data) && fpu_status_reg_r == stf_r)
        else $error("status load did not overwrite flags");

    chk_to_fp: assert property (
        is_to_fp |=> fp_regs_r[$past(fp_xfer_reg)] == $past(cpu_src_data))
        else $error("cpu to fp copy wrong");

    chk_xfer_flags: assert property (
        (is_to_fp || is_from_fp) |=> $stable(stf_r))
        else $error("register transfer touched flags");

    chk_from_fp: assert property (
        is_from_fp |=> cpu_wr_valid_r && cpu_wr_data_r == $past(xfer_val))
        else $error("fp to cpu move wrong");

    chk_bus_ack: assert property (
        (bus_req && wait_r) |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not one cycle late");

    chk_resvd_skip: assert property (
        (is_cmov && cond_reserved) |=> irq_stat_r[`FPMV_EVT_RESVD] && irq_stat_r[`FPMV_EVT_SKIPPED]
            && fp_regs_r[$past(fp_dest_reg)] == $past(dest_val))
        else $error("reserved code moved or went unreported");

    chk_ctrl_off: assert property (
        (instr_valid && !enable_r) |=> $stable(stf_r) && !cpu_wr_valid_r)
        else $error("disabled unit executed an instruction");

    chk_wb_pulse: assert property (
        cpu_wr_valid_r |-> $past(is_from_fp))
        else $error("write-back without a move out");

    // ==========================================
    // Interrupt checks
    chk_stat_sticky: assert property (
        !stat_rd_clr |=> (irq_stat_r & $past(irq_stat_r)) == $past(irq_stat_r))
        else $error("event bit lost without a read");

    chk_read_clear: assert property (
        stat_rd_clr |=> irq_stat_r == $past(evt))
        else $error("status read did not clear old events");

    chk_irq_level: assert property (
        irq_r == |(irq_stat_r & $past(irq_mask_r)))
        else $error("interrupt level disagrees with status and mask");
endmodule : fpmv_top
`default_nettype wire

/* testbench/fpmv_cpu_model.sv */
// Host CPU pipeline model issuing register move instructions
`timescale 1ns/1ps
`default_nettype none
`include "fpmv_params.svh"
module fpmv_cpu_model (
    // Clock
    input wire logic clk_sys,
    // Instruction issue
    output logic instr_valid,
    output logic [15:0] lower_opcode_word,
    output logic [15:0] upper_opcode_word,
    output logic [31:0] cpu_src_data,
    output logic [31:0] mem_rd_data,
    // Write-back
    input wire logic cpu_wr_valid_r,
    input wire logic [7:0] cpu_wr_loc_r,
    input wire logic [31:0] cpu_wr_data_r
);
    // ====
    // Issue
    int wb_count = 0;
    logic [7:0] wb_loc = 8'h00;
    logic [31:0] wb_data = 32'h0;
    initial begin
        instr_valid = 1'b0;
        lower_opcode_word = 16'h0000;
        upper_opcode_word = 16'h0000;
        cpu_src_data = 32'h0;
        mem_rd_data = 32'h0;
    end
    // No interlock in the unit, so spacing is kept here
    task automatic issue(input logic [15:0] lo, input logic [15:0] up,
        input logic [31:0] src, input logic [31:0] mem, input int gap);
        int g;
        g = (gap < 1) ? 1 : gap;
        if (lo[15:8] == `FPMV_TOFP_OP && g < 4) begin
            g = 4;
        end
        instr_valid <= 1'b1;
        lower_opcode_word <= lo;
        upper_opcode_word <= up;
        cpu_src_data <= src;
        mem_rd_data <= mem;
        @(posedge clk_sys);
        // Released operands must not keep looking valid
        instr_valid <= 1'b0;
        cpu_src_data <= ~src;
        mem_rd_data <= ~mem;
        // Slots are empty cycles; only single-cycle ops precede a move out
        repeat (g) @(posedge clk_sys);
    endtask : issue
    // ====
    // Write-back capture
    always @(posedge clk_sys) begin
        if (cpu_wr_valid_r === 1'b1) begin
            wb_count <= wb_count + 1;
            wb_loc <= cpu_wr_loc_r;
            wb_data <= cpu_wr_data_r;
        end
    end
endmodule : fpmv_cpu_model
`default_nettype wire

/* testbench/test_fpu_register_move_unit.sv */
// Self-checking bench for the floating-point register move unit
`timescale 1ns/1ps
`default_nettype none
`include "fpmv_params.svh"
module test_fpu_register_move_unit;
    // ====
    // Signals
    logic clk_sys;
    logic reset;
    logic instr_valid;
    logic [15:0] lower_opcode_word;
    logic [15:0] upper_opcode_word;
    logic [31:0] cpu_src_data;
    logic [31:0] mem_rd_data;
    logic cpu_wr_valid_r;
    logic [7:0] cpu_wr_loc_r;
    logic [31:0] cpu_wr_data_r;
    logic [31:0] fpu_status_reg_r;
    logic [4:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic irq_r;
    logic [31:0] rv;
    int fail_count = 0;
    int comparisons = 0;
    fpmv_top fpmv_top_i (.clk_sys, .reset, .instr_valid, .lower_opcode_word,
        .upper_opcode_word, .cpu_src_data, .mem_rd_data, .cpu_wr_valid_r,
        .cpu_wr_loc_r, .cpu_wr_data_r, .fpu_status_reg_r, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .irq_r);
    fpmv_cpu_model fpmv_cpu_model_i (.clk_sys, .instr_valid, .lower_opcode_word,
        .upper_opcode_word, .cpu_src_data, .mem_rd_data, .cpu_wr_valid_r,
        .cpu_wr_loc_r, .cpu_wr_data_r);
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // ====
    // Helpers
    task automatic final_report;
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // One Avalon access; the extra edge keeps requests from touching
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        rd = avs_readdata;
        if (avs_waitrequest !== 1'b0) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, avs_waitrequest, 1'b0);
            final_report();
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask : bus
    task automatic rd_fp(input logic [2:0] idx, output logic [31:0] v);
        bus(1'b1, 5'h10, {29'h0, idx}, v);
        bus(1'b0, 5'h14, 32'h0, v);
    endtask : rd_fp
    task automatic op(input logic [15:0] lo, input logic [15:0] up,
        input logic [31:0] d, input int gap);
        fpmv_cpu_model_i.issue(lo, up, d, d, gap);
    endtask : op
    function automatic logic cond_exp(input logic [3:0] c, input logic [31:0] s);
        case (c)
            4'h0: return !s[3];
            4'h1: return s[3];
            4'h2: return !s[3] && !s[2];
            4'h3: return !s[2];
            4'h4: return s[2];
            4'h5: return s[3] && s[2];
            4'ha: return s[6];
            4'hb: return !s[6];
            4'hc: return s[1];
            4'hd: return s[0];
            4'he: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : cond_exp
    // ====
    // Scenarios
    task automatic t_regs;
        bus(1'b0, 5'h00, 32'h0, rv);
        check(rv, `FPMV_STF_RST);
        bus(1'b0, 5'h0c, 32'h0, rv);
        check(rv, 32'h1);
        bus(1'b0, 5'h08, 32'h0, rv);
        check(rv, 32'h0);
        // Disabled unit ignores a status load
        bus(1'b1, 5'h0c, 32'h0, rv);
        op(`FPMV_STFLD_OP, 16'h0000, 32'h0000_00ff, 1);
        check(fpu_status_reg_r, 32'h0);
        bus(1'b1, 5'h0c, 32'h1, rv);
        bus(1'b1, 5'h18, 32'hffff_ffff, rv);
        bus(1'b0, 5'h18, 32'h0, rv);
        check(rv, 32'h0);
        // Status is read-only from the bus
        bus(1'b1, 5'h00, 32'hffff_ffff, rv);
        check(fpu_status_reg_r, 32'h0);
    endtask : t_regs
    task automatic t_to_fp;
        op({`FPMV_TOFP_OP, 8'h0a}, 16'h0001, 32'hc040_0000, 4);
        check(fpu_status_reg_r, 32'h0);
        rd_fp(3'h1, rv);
        check(rv, 32'hc040_0000);
        op({`FPMV_TOFP_OP, 8'h09}, 16'h0005, 32'h8000_0001, 4);
        rd_fp(3'h5, rv);
        check(rv, 32'h8000_0001);
        op(`FPMV_STFLD_OP, 16'h0000, 32'h0000_0043, 1);
        check(fpu_status_reg_r, 32'h43);
    endtask : t_to_fp
    task automatic t_cond;
        logic [31:0] pats [2];
        pats = '{32'h43, 32'h0c};
        for (int p = 0; p < 2; p++) begin
            op(`FPMV_STFLD_OP, 16'h0000, pats[p], 1);
            for (int c = 0; c < 15; c++) begin
                op({`FPMV_TOFP_OP, 8'h0a}, 16'h0002, 32'h0, 4);
                op({`FPMV_CMOV_OP, 4'(c)}, 16'h000a, 32'h0, 1);
                check(fpu_status_reg_r, pats[p]);
                rd_fp(3'h2, rv);
                check(rv, cond_exp(4'(c), pats[p]) ? 32'hc040_0000 : 32'h0);
            end
        end
    endtask : t_cond
    task automatic t_uncond_flag_update;
        logic [15:0] ups [3];
        logic [31:0] exps [3];
        ups = '{16'h000b, 16'h003c, 16'h002e};
        exps = '{32'h57, 32'h6b, 32'h5b};
        op(`FPMV_STFLD_OP, 16'h0000, 32'h0000_0043, 1);
        for (int i = 0; i < 3; i++) begin
            op({`FPMV_CMOV_OP, 4'hf}, ups[i], 32'h0, 1);
            check(fpu_status_reg_r, exps[i]);
        end
        rd_fp(3'h3, rv);
        check(rv, 32'hc040_0000);
    endtask : t_uncond_flag_update
    task automatic t_to_cpu;
        int n;
        n = fpmv_cpu_model_i.wb_count;
        op({`FPMV_FROMFP_OP, 8'h07}, 16'h0001, 32'h0, 2);
        check(32'(fpmv_cpu_model_i.wb_count - n), 32'h1);
        check({24'h0, fpmv_cpu_model_i.wb_loc}, 32'h7);
        check(fpmv_cpu_model_i.wb_data, 32'hc040_0000);
        check(fpu_status_reg_r, 32'h5b);
    endtask : t_to_cpu
    task automatic t_irq;
        bus(1'b1, 5'h08, 32'h8, rv);
        bus(1'b0, 5'h04, 32'h0, rv);
        repeat (2) @(posedge clk_sys);
        check({31'h0, irq_r}, 32'h0);
        op(`FPMV_STFLD_OP, 16'h0000, 32'h0000_0043, 2);
        check({31'h0, irq_r}, 32'h1);
        bus(1'b0, 5'h04, 32'h0, rv);
        check(rv & 32'h8, 32'h8);
        repeat (2) @(posedge clk_sys);
        check({31'h0, irq_r}, 32'h0);
        // Masked event must stay silent
        bus(1'b1, 5'h08, 32'h0, rv);
        op(`FPMV_STFLD_OP, 16'h0000, 32'h0000_0043, 2);
        check({31'h0, irq_r}, 32'h0);
        // Every event kind reaches the sticky status
        op({`FPMV_CMOV_OP, 4'h6}, 16'h000a, 32'h0, 1);
        op({`FPMV_CMOV_OP, 4'he}, 16'h000a, 32'h0, 1);
        op({`FPMV_FROMFP_OP, 8'h07}, 16'h0001, 32'h0, 1);
        bus(1'b0, 5'h04, 32'h0, rv);
        check(rv, 32'h1f);
        check({31'h0, irq_r}, 32'h0);
    endtask : t_irq
    // ====
    // Main sequence
    initial begin
        reset = 1'b1;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        t_regs();
        t_to_fp();
        t_cond();
        t_uncond_flag_update();
        t_to_cpu();
        t_irq();
        final_report();
    end
endmodule : test_fpu_register_move_unit
`default_nettype wire
